// file: core/vilu_defs.vh
`ifndef VILU_DEFS_VH
`define VILU_DEFS_VH
// ****************************************
// Register map and field positions
// ****************************************
`define VILU_ADDR_OPTION 8'hc8
`define VILU_ADDR_LATCH 8'hed
`define VILU_OPT_EL1 6
`define VILU_OPT_ES2 5
`define VILU_OPT_GEN 4
`define VILU_LAT_SYNC_EDGE 7
`define VILU_LAT_SYNC_EN 6
`define VILU_LAT_PWR_FLAG 5
`define VILU_LAT_PWR_EN 4
`define VILU_LAT_PWR_EDGE 3
`define VILU_LAT_NMI_FLAG 2
`define VILU_LAT_NMI_EN 1
`define VILU_LAT_NMI_EDGE 0
// ****************************************
// Vector addresses and reset values
// ****************************************
`define VILU_VEC0_ADDR 12'hffc
`define VILU_VEC1_ADDR 12'hff6
`define VILU_VEC2_ADDR 12'hff4
`define VILU_VEC3_ADDR 12'hff2
`define VILU_VEC4_ADDR 12'hff0
`define VILU_RESET_VEC_ADDR 12'hffe
`define VILU_OPT_RESET 8'h00
// ****************************************
// Core mode encoding
// ****************************************
`define VILU_MODE_NORMAL 2'h0
`define VILU_MODE_INT 2'h1
`define VILU_MODE_NMI 2'h2
`define VILU_MODE_NMI_FROM_INT 2'h3
`endif

// file: core/vilu_unit.v
// Operation
// - Option register at C8h is write-only; whole-byte writes only.
// - Option bit 6 selects vector-1 low level (1) or falling edge (0); resets 0.
// - Option bit 5 picks vector-2 edge, 1 rising; software keeps 0 for timers.
// - Option bit 4 globally enables; when 0 only the non-maskable vector passes.
// - Latch register bits: sync edge, sync en, pwr flag/en/edge, nmi flag/en/edge.
// - Non-maskable and power-in latches capture rising when edge bit 1, else falling.
// - Latched non-maskable raises vector 0, power-in vector 4, only when enabled.
// - Flags read 1 after capture; writing 1 clears the latch.
// - Sync edge bit 1 captures rising sync edges, 0 falling; resets 0.
// - Sync latch feeds vector 2 only when enabled; writing enable 1 clears latch.
// - Reading sync enable gives latch state; reading sync edge gives pin level.
// - Entry swaps flags, pushes PC, inhibits requests, clears edge flop, loads vector.
// - Return restores previous flag set and pops the saved PC.
// - Vector 0 edge request is cleared only by servicing; pre-empts maskable routines.
// - Timer-3 and port requests are ANDed active-low onto vector 1 at 0FF6h.
// - A port held low in level mode re-enters vector 1 right after return.
// - Sync, timer-2 and serial requests ANDed onto vector 2; edge cleared by service.
// - Edge switch to rising while sync high or disabled gives a spurious request.
// - Timer-1 and display channel requests ANDed onto vector 3, low level.
// - Power-in and converter requests ANDed onto vector 4 at 0FF0h, low level.
// - Global disable keeps stored edge requests; they pend when re-enabled.
// - Timer request flags reach the core only while their mask bit is 1.
// - Vector 1 highest to 4 lowest; vector 0 above all; maskables never nest.
// - Requests are sampled in the last cycle of each instruction.
// - After reset the core is in non-maskable mode until the first return.
// - Vector 2 at FF4h and vector 3 at FF2h in the fixed page.
`timescale 1ns/1ps
`include "vilu_defs.vh"
module vilu_unit
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Data space access from the core
  input wire [7:0] data_addr,
  input wire [7:0] data_wdata,
  input wire data_wr,
  input wire data_rd,
  output reg [7:0] data_rdata,
  output wire data_hit,
  // External pins
  input wire nonmask_pin,
  input wire power_in_pin,
  input wire vsync_pin,
  // Peripheral request lines, active low
  input wire timer3_req_n,
  input wire port_ab_req_n,
  input wire timer2_req_n,
  input wire serial_req_n,
  input wire timer1_req_n,
  input wire ddc_req_n,
  input wire adc_req_n,
  // Raw timer flags with masks
  input wire [2:0] timer_request_flag,
  input wire [2:0] timer_int_mask,
  output wire [2:0] timer_req_to_core,
  // Core sequencer handshake
  input wire instr_last_cycle,
  input wire return_from_interrupt,
  input wire [11:0] pc_in,
  input wire [1:0] flags_in,
  output reg int_take,
  output reg [11:0] vector_addr,
  output reg [11:0] pc_push,
  output reg pc_push_en,
  output reg pc_pop_en,
  output reg [1:0] flags_out,
  output reg [1:0] core_mode
);

  // ****************************************
  // Option and latch control bits
  // ****************************************
  reg vec1_edge_level_sel_reg;
  reg vec2_edge_sel_reg;
  reg global_int_enable_reg;
  reg sync_edge_status_bit_reg;
  reg sync_enable_latch_bit_reg;
  reg power_in_int_enable_reg;
  reg power_in_edge_sel_reg;
  reg nonmask_int_enable_reg;
  reg nonmask_edge_sel_reg;
  reg power_in_latch_flag_reg;
  reg nonmask_latch_flag_reg;
  reg sync_latch_reg;
  reg vec0_pend_reg;
  reg vec1_edge_reg;
  reg vec2_edge_reg;
  reg [1:0] flags_normal_reg;
  reg [1:0] flags_int_reg;
  reg [1:0] flags_nmi_reg;
  reg [11:0] stack_reg [0:1];

  wire wr_opt = data_wr && (data_addr == `VILU_ADDR_OPTION);
  wire wr_lat = data_wr && (data_addr == `VILU_ADDR_LATCH);
  assign data_hit = (data_addr == `VILU_ADDR_OPTION) || (data_addr == `VILU_ADDR_LATCH);

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  reg [2:0] pin_prev_reg;
  always @(posedge clk)
  begin
    pin_meta_reg <= {vsync_pin, power_in_pin, nonmask_pin};
    pin_sync_reg <= pin_meta_reg;
    pin_prev_reg <= pin_sync_reg;
  end
  wire nmi_s = pin_sync_reg[0];
  wire pwr_s = pin_sync_reg[1];
  wire vs_s = pin_sync_reg[2];
  // Level seen through the edge select: an edge of this level is the trigger
  wire nmi_lvl = nmi_s ~^ nonmask_edge_sel_reg;
  wire nmi_lvl_prev = pin_prev_reg[0] ~^ nonmask_edge_sel_reg;
  wire pwr_lvl = pwr_s ~^ power_in_edge_sel_reg;
  wire pwr_lvl_prev = pin_prev_reg[1] ~^ power_in_edge_sel_reg;
  wire vs_lvl = vs_s ~^ sync_edge_status_bit_reg;
  wire vs_lvl_prev = pin_prev_reg[2] ~^ sync_edge_status_bit_reg;
  // Both levels use the current select, so changing the select while the pin holds steady does not fire
  wire nmi_edge = nmi_lvl && !nmi_lvl_prev;
  wire pwr_edge = pwr_lvl && !pwr_lvl_prev;
  wire vs_edge = vs_lvl && !vs_lvl_prev;

  // ****************************************
  // Request combining
  // ****************************************
  wire nmi_line_n = !(nonmask_latch_flag_reg && nonmask_int_enable_reg);
  wire pwr_line_n = !(power_in_latch_flag_reg && power_in_int_enable_reg);
  wire vs_line_n = !(sync_latch_reg && sync_enable_latch_bit_reg);
  wire vec1_n = timer3_req_n & port_ab_req_n;
  wire vec2_n = vs_line_n & timer2_req_n & serial_req_n;
  wire vec3_n = timer1_req_n & ddc_req_n;
  wire vec4_n = pwr_line_n & adc_req_n;
  assign timer_req_to_core = timer_request_flag & timer_int_mask;

  // Vector 2 edge: a fall of the line seen through the edge select, so a select flip can fire
  reg vec0_prev_reg;
  reg vec1_prev_reg;
  reg vec2_lvl_prev_reg;
  wire vec2_lvl = vec2_n ^ vec2_edge_sel_reg;
  wire vec2_fall = !vec2_lvl && vec2_lvl_prev_reg;
  wire vec1_fall = !vec1_n && vec1_prev_reg;
  wire vec0_fall = nmi_line_n == 1'b0 && vec0_prev_reg;

  wire maskable_ok = global_int_enable_reg && (core_mode == `VILU_MODE_NORMAL);
  wire req1 = vec1_edge_level_sel_reg ? !vec1_n : vec1_edge_reg;
  wire req2 = vec2_edge_reg;
  wire req3 = !vec3_n;
  wire req4 = !vec4_n;
  wire nmi_ok = vec0_pend_reg && (core_mode != `VILU_MODE_NMI) && (core_mode != `VILU_MODE_NMI_FROM_INT);

  // ****************************************
  // Register reads
  // ****************************************
  always @*
  begin
    data_rdata = 8'h00;
    if (data_rd && data_addr == `VILU_ADDR_LATCH)
    begin
      data_rdata[`VILU_LAT_SYNC_EDGE] = vs_s;
      data_rdata[`VILU_LAT_SYNC_EN] = sync_latch_reg;
      data_rdata[`VILU_LAT_PWR_FLAG] = power_in_latch_flag_reg;
      data_rdata[`VILU_LAT_NMI_FLAG] = nonmask_latch_flag_reg;
    end
  end

  // ****************************************
  // Sequencer entry and return
  // ****************************************
  reg take;
  reg take_nmi;
  reg [11:0] take_vec;
  always @*
  begin
    take = 1'b0;
    take_nmi = 1'b0;
    take_vec = `VILU_VEC0_ADDR;
    if (instr_last_cycle)
    begin
      if (nmi_ok)
      begin
        take = 1'b1;
        take_nmi = 1'b1;
      end
      else if (maskable_ok && req1)
      begin
        take = 1'b1;
        take_vec = `VILU_VEC1_ADDR;
      end
      else if (maskable_ok && req2)
      begin
        take = 1'b1;
        take_vec = `VILU_VEC2_ADDR;
      end
      else if (maskable_ok && req3)
      begin
        take = 1'b1;
        take_vec = `VILU_VEC3_ADDR;
      end
      else if (maskable_ok && req4)
      begin
        take = 1'b1;
        take_vec = `VILU_VEC4_ADDR;
      end
    end
  end

  wire [1:0] flags_cur = (core_mode == `VILU_MODE_NORMAL) ? flags_normal_reg :
                         (core_mode == `VILU_MODE_INT) ? flags_int_reg : flags_nmi_reg;

  always @(posedge clk)
  begin
    if (rst)
    begin
      vec1_edge_level_sel_reg <= 1'b0;
      vec2_edge_sel_reg <= 1'b0;
      global_int_enable_reg <= 1'b0;
      sync_edge_status_bit_reg <= 1'b0;
      sync_enable_latch_bit_reg <= 1'b0;
      power_in_int_enable_reg <= 1'b0;
      power_in_edge_sel_reg <= 1'b0;
      nonmask_int_enable_reg <= 1'b0;
      nonmask_edge_sel_reg <= 1'b0;
      power_in_latch_flag_reg <= 1'b0;
      nonmask_latch_flag_reg <= 1'b0;
      sync_latch_reg <= 1'b0;
      vec0_pend_reg <= 1'b0;
      vec1_edge_reg <= 1'b0;
      vec2_edge_reg <= 1'b0;
      vec0_prev_reg <= 1'b1;
      vec1_prev_reg <= 1'b1;
      vec2_lvl_prev_reg <= 1'b1;
      flags_normal_reg <= 2'h0;
      flags_int_reg <= 2'h0;
      flags_nmi_reg <= 2'h0;
      stack_reg[0] <= 12'h000;
      stack_reg[1] <= 12'h000;
      core_mode <= `VILU_MODE_NMI;
      int_take <= 1'b0;
      vector_addr <= `VILU_RESET_VEC_ADDR;
      pc_push <= 12'h000;
      pc_push_en <= 1'b0;
      pc_pop_en <= 1'b0;
      flags_out <= 2'h0;
    end
    else
    begin
      vec0_prev_reg <= nmi_line_n;
      vec1_prev_reg <= vec1_n;
      vec2_lvl_prev_reg <= vec2_lvl;
      if (wr_opt)
      begin
        vec1_edge_level_sel_reg <= data_wdata[`VILU_OPT_EL1];
        vec2_edge_sel_reg <= data_wdata[`VILU_OPT_ES2];
        global_int_enable_reg <= data_wdata[`VILU_OPT_GEN];
      end
      if (wr_lat)
      begin
        sync_edge_status_bit_reg <= data_wdata[`VILU_LAT_SYNC_EDGE];
        sync_enable_latch_bit_reg <= data_wdata[`VILU_LAT_SYNC_EN];
        power_in_int_enable_reg <= data_wdata[`VILU_LAT_PWR_EN];
        power_in_edge_sel_reg <= data_wdata[`VILU_LAT_PWR_EDGE];
        nonmask_int_enable_reg <= data_wdata[`VILU_LAT_NMI_EN];
        nonmask_edge_sel_reg <= data_wdata[`VILU_LAT_NMI_EDGE];
      end
      // Captures win over software clears in the same cycle
      if (nmi_edge)
        nonmask_latch_flag_reg <= 1'b1;
      else if (wr_lat && data_wdata[`VILU_LAT_NMI_FLAG])
        nonmask_latch_flag_reg <= 1'b0;
      if (pwr_edge)
        power_in_latch_flag_reg <= 1'b1;
      else if (wr_lat && data_wdata[`VILU_LAT_PWR_FLAG])
        power_in_latch_flag_reg <= 1'b0;
      if (vs_edge)
        sync_latch_reg <= 1'b1;
      else if (wr_lat && data_wdata[`VILU_LAT_SYNC_EN])
        sync_latch_reg <= 1'b0;
      // Edge flops keep their state through global disable
      if (vec0_fall)
        vec0_pend_reg <= 1'b1;
      else if (take && take_nmi)
        vec0_pend_reg <= 1'b0;
      if (vec1_fall)
        vec1_edge_reg <= 1'b1;
      else if (take && !take_nmi && take_vec == `VILU_VEC1_ADDR)
        vec1_edge_reg <= 1'b0;
      if (vec2_fall)
        vec2_edge_reg <= 1'b1;
      else if (take && !take_nmi && take_vec == `VILU_VEC2_ADDR)
        vec2_edge_reg <= 1'b0;
      int_take <= take;
      pc_push_en <= take;
      pc_pop_en <= 1'b0;
      if (take)
      begin
        vector_addr <= take_vec;
        pc_push <= pc_in;
        if (core_mode == `VILU_MODE_NORMAL)
          flags_normal_reg <= flags_in;
        else
          flags_int_reg <= flags_in;
        stack_reg[1] <= stack_reg[0];
        stack_reg[0] <= pc_in;
        if (take_nmi)
        begin
          flags_out <= flags_nmi_reg;
          core_mode <= (core_mode == `VILU_MODE_INT) ? `VILU_MODE_NMI_FROM_INT : `VILU_MODE_NMI;
        end
        else
        begin
          flags_out <= flags_int_reg;
          core_mode <= `VILU_MODE_INT;
        end
      end
      else if (return_from_interrupt && core_mode != `VILU_MODE_NORMAL)
      begin
        pc_pop_en <= 1'b1;
        vector_addr <= stack_reg[0];
        stack_reg[0] <= stack_reg[1];
        if (core_mode == `VILU_MODE_INT)
          flags_int_reg <= flags_in;
        else
          flags_nmi_reg <= flags_in;
        if (core_mode == `VILU_MODE_NMI_FROM_INT)
        begin
          flags_out <= flags_int_reg;
          core_mode <= `VILU_MODE_INT;
        end
        else
        begin
          flags_out <= flags_normal_reg;
          core_mode <= `VILU_MODE_NORMAL;
        end
      end
      else
        flags_out <= flags_cur;
    end
  end

endmodule

// file: verification/vilu_unit_assertions.sv
`timescale 1ns/1ps
`include "vilu_defs.vh"
module vilu_unit_assertions
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Data space
  input wire [7:0] data_addr,
  input wire [7:0] data_wdata,
  input wire data_wr,
  input wire [7:0] data_rdata,
  input wire data_hit,
  // Timer flags
  input wire [2:0] timer_request_flag,
  input wire [2:0] timer_int_mask,
  input wire [2:0] timer_req_to_core,
  // Core handshake
  input wire instr_last_cycle,
  input wire return_from_interrupt,
  input wire int_take,
  input wire [11:0] vector_addr,
  input wire pc_push_en,
  input wire pc_pop_en,
  input wire [1:0] core_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Shadow of the global enable
  // ****
  // The option register reads back zero, so the last written value is kept here
  reg gen_reg;
  always @(posedge clk)
    if (rst)
      gen_reg <= 1'b0;
    else if (data_wr && data_addr == `VILU_ADDR_OPTION)
      gen_reg <= data_wdata[`VILU_OPT_GEN];
  chk_opt_write_only: assert property (data_addr == `VILU_ADDR_OPTION |-> data_rdata == 8'h00 && data_hit)
    else $error("option register not write-only");
  chk_gen_blocks: assert property (int_take && vector_addr != `VILU_VEC0_ADDR |-> $past(gen_reg))
    else $error("maskable taken while globally disabled");
  chk_take_push: assert property (int_take |-> pc_push_en && core_mode != `VILU_MODE_NORMAL)
    else $error("entry without push or mode change");
  chk_pop_cause: assert property (pc_pop_en |-> $past(return_from_interrupt))
    else $error("pop without return");
  chk_ret_mode: assert property (pc_pop_en && $past(core_mode) == `VILU_MODE_INT |->
    core_mode == `VILU_MODE_NORMAL)
    else $error("return did not restore normal mode");
  chk_timer_mask: assert property (timer_req_to_core == (timer_request_flag & timer_int_mask))
    else $error("timer flag passed without mask");
  chk_no_nest: assert property (int_take && vector_addr != `VILU_VEC0_ADDR |->
    $past(core_mode) == `VILU_MODE_NORMAL && core_mode == `VILU_MODE_INT)
    else $error("maskable routine nested");
  chk_take_slot: assert property (int_take |-> $past(instr_last_cycle))
    else $error("request taken outside last cycle");
  chk_reset_mode: assert property ($fell(rst) |-> core_mode == `VILU_MODE_NMI &&
    vector_addr == `VILU_RESET_VEC_ADDR)
    else $error("reset state wrong");
  chk_vector_table: assert property (int_take |->
    vector_addr inside {12'hffc, 12'hff6, 12'hff4, 12'hff2, 12'hff0})
    else $error("vector address outside table");
endmodule
bind vilu_unit vilu_unit_assertions i_chk (.clk, .rst, .data_addr, .data_wdata, .data_wr, .data_rdata, .data_hit,
  .timer_request_flag, .timer_int_mask, .timer_req_to_core, .instr_last_cycle, .return_from_interrupt, .int_take,
  .vector_addr, .pc_push_en, .pc_pop_en, .core_mode);

// file: verification/vilu_core_model.sv
`timescale 1ns/1ps
module vilu_core_model
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bench command
  input wire ret_req,
  // From the unit
  input wire int_take,
  input wire pc_pop_en,
  input wire [11:0] vector_addr,
  // To the unit
  output reg instr_last_cycle,
  output reg return_from_interrupt,
  output reg [11:0] pc_in,
  output reg [1:0] flags_in
);
  reg [1:0] len_reg;
  // ****
  // Instructions of one to three cycles
  // ****
  always @(posedge clk)
    if (rst)
    begin
      len_reg <= 2'h0;
      instr_last_cycle <= 1'b0;
      return_from_interrupt <= 1'b0;
      pc_in <= 12'h100;
      flags_in <= 2'h0;
    end
    else
    begin
      return_from_interrupt <= ret_req;
      // Entry and return cycles are never a sampling slot
      instr_last_cycle <= !ret_req && !int_take && len_reg == 2'h0;
      len_reg <= (len_reg == 2'h0) ? 2'($urandom % 3) : len_reg - 2'h1;
      flags_in <= 2'($urandom);
      if (int_take || pc_pop_en)
        pc_in <= vector_addr;
      else if (instr_last_cycle)
        pc_in <= pc_in + 12'h001;
    end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "vilu_defs.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] data_addr = 8'h00;
  reg [7:0] data_wdata = 8'h00;
  reg data_wr = 1'b0;
  reg data_rd = 1'b0;
  reg nonmask_pin = 1'b1;
  reg power_in_pin = 1'b0;
  reg vsync_pin = 1'b1;
  reg [6:0] req_n = 7'h7f;
  reg [2:0] timer_request_flag = 3'h0;
  reg [2:0] timer_int_mask = 3'h0;
  reg ret_req = 1'b0;
  wire [7:0] data_rdata;
  wire data_hit, instr_last_cycle, return_from_interrupt, int_take, pc_push_en, pc_pop_en;
  wire [2:0] timer_req_to_core;
  wire [11:0] pc_in, vector_addr, pc_push;
  wire [1:0] flags_in, flags_out, core_mode;
  int fails = 0;
  int samples_checked = 0;
  int exp_q[$];
  int mode_q[$];
  int pc_q[$];
  int fset[3] = '{0, 0, 0};
  int cur = 2;
  int ev = 0;
  int tgt = 0;
  int src[5] = '{4, 5, 6, 3, 1};
  int vec[5] = '{12'hff2, 12'hff2, 12'hff0, 12'hff4, 12'hff6};
  reg [11:0] pc_h0;
  reg [1:0] fl_h0;
  reg [7:0] rd_val;
  always #5 clk = ~clk;
  vilu_unit i_dut (.clk, .rst, .data_addr, .data_wdata, .data_wr, .data_rd, .data_rdata, .data_hit,
    .nonmask_pin, .power_in_pin, .vsync_pin, .timer3_req_n(req_n[0]), .port_ab_req_n(req_n[1]),
    .timer2_req_n(req_n[2]), .serial_req_n(req_n[3]), .timer1_req_n(req_n[4]), .ddc_req_n(req_n[5]),
    .adc_req_n(req_n[6]), .timer_request_flag, .timer_int_mask, .timer_req_to_core, .instr_last_cycle,
    .return_from_interrupt, .pc_in, .flags_in, .int_take, .vector_addr, .pc_push, .pc_push_en,
    .pc_pop_en, .flags_out, .core_mode);
  vilu_core_model i_core (.clk, .rst, .ret_req, .int_take, .pc_pop_en, .vector_addr, .instr_last_cycle,
    .return_from_interrupt, .pc_in, .flags_in);
  task check(input string nm, input [11:0] got, input [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    data_addr <= a;
    data_wdata <= d;
    data_wr <= 1'b1;
    @(posedge clk);
    data_wr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    data_addr <= a;
    data_rd <= 1'b1;
    @(negedge clk);
    rd_val = data_rdata;
    @(posedge clk);
    data_rd <= 1'b0;
  endtask
  task wait_q;
    for (int i = 0; i < 80 && exp_q.size() != 0; i++)
      @(posedge clk);
    check("pending takes", exp_q.size(), 0);
    exp_q.delete();
  endtask
  task do_ret;
    int m;
    // The mode to come back to is the one saved by the reference at the last entry
    m = (mode_q.size() > 0) ? mode_q[$] : 0;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("pop", pc_pop_en, 1);
    check("mode", core_mode, m);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****
  // Reference of expected entries
  // ****
  always @(posedge clk)
  begin
    pc_h0 <= pc_in;
    fl_h0 <= flags_in;
    timer_request_flag <= 3'($urandom);
    timer_int_mask <= 3'($urandom);
  end
  always @(negedge clk)
    if (!rst)
    begin
      check("to core", timer_req_to_core, timer_request_flag & timer_int_mask);
      if (int_take === 1'b1)
      begin
        check("stray take", exp_q.size() > 0, 1);
        if (exp_q.size() > 0)
        begin
          ev = exp_q.pop_front();
          check("vector", vector_addr, ev);
        end
        check("pushed pc", pc_push, pc_h0);
        tgt = (ev == `VILU_VEC0_ADDR) ? 2 : 1;
        check("entry flags", flags_out, fset[tgt]);
        fset[cur] = fl_h0;
        mode_q.push_back(cur);
        pc_q.push_back(pc_h0);
        cur = tgt;
      end
      if (pc_pop_en === 1'b1)
      begin
        fset[cur] = fl_h0;
        cur = (mode_q.size() > 0) ? mode_q.pop_back() : 0;
        check("return flags", flags_out, fset[cur]);
        if (pc_q.size() > 0)
          check("popped pc", vector_addr, pc_q.pop_back());
      end
    end
    else
    begin
      cur = 2;
      fset = '{0, 0, 0};
      mode_q.delete();
      pc_q.delete();
    end
  initial
  begin
    #100000;
    fails++;
    report_and_stop;
  end
  // ****
  // Tests
  // ****
  initial
  begin
    void'($urandom(32'hb3f61907));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset mode", core_mode, `VILU_MODE_NMI);
    rd(`VILU_ADDR_OPTION);
    check("option read", rd_val, 8'h00);
    rd(8'h3c);
    check("unmapped", {3'h0, data_hit, rd_val}, 12'h000);
    rd(`VILU_ADDR_LATCH);
    check("latch reset", rd_val & 8'he4, 8'h80);
    do_ret;
    $display("test reset done");
    wr(`VILU_ADDR_LATCH, 8'h02);
    @(posedge clk) nonmask_pin <= 1'b0;
    exp_q.push_back(12'hffc);
    wait_q;
    rd(`VILU_ADDR_LATCH);
    check("nmi flag", rd_val[2], 1);
    wr(`VILU_ADDR_LATCH, 8'h06);
    rd(`VILU_ADDR_LATCH);
    check("nmi clear", rd_val[2], 0);
    nonmask_pin <= 1'b1;
    do_ret;
    wr(`VILU_ADDR_LATCH, 8'h00);
    @(posedge clk) nonmask_pin <= 1'b0;
    repeat (20) @(posedge clk);
    $display("test nonmask done");
    wr(`VILU_ADDR_OPTION, 8'h10);
    wr(`VILU_ADDR_LATCH, 8'h18);
    @(posedge clk) power_in_pin <= 1'b1;
    exp_q.push_back(12'hff0);
    wait_q;
    rd(`VILU_ADDR_LATCH);
    check("power flag", rd_val[5], 1);
    wr(`VILU_ADDR_LATCH, 8'h38);
    do_ret;
    $display("test power done");
    wr(`VILU_ADDR_OPTION, 8'h00);
    req_n[2] <= 1'b0;
    req_n[0] <= 1'b0;
    repeat (20) @(posedge clk);
    wr(`VILU_ADDR_OPTION, 8'h50);
    exp_q.push_back(12'hff6);
    wait_q;
    exp_q.push_back(12'hff6);
    do_ret;
    wait_q;
    req_n[0] <= 1'b1;
    exp_q.push_back(12'hff4);
    do_ret;
    wait_q;
    req_n[2] <= 1'b1;
    do_ret;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) req_n <= ~(7'h01 << src[i]);
      exp_q.push_back(vec[i]);
      wait_q;
      req_n <= 7'h7f;
      do_ret;
    end
    $display("test sources done");
    wr(`VILU_ADDR_OPTION, 8'h00);
    wr(`VILU_ADDR_LATCH, 8'h40);
    @(posedge clk) vsync_pin <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`VILU_ADDR_LATCH);
    check("sync status", rd_val & 8'hc0, 8'h40);
    wr(`VILU_ADDR_OPTION, 8'h10);
    exp_q.push_back(12'hff4);
    wait_q;
    vsync_pin <= 1'b1;
    do_ret;
    wr(`VILU_ADDR_LATCH, 8'h40);
    rd(`VILU_ADDR_LATCH);
    check("sync clear", rd_val & 8'hc0, 8'h80);
    $display("test sync done");
    // Flipping the vector-2 select to rising while the line idles high must fire once
    exp_q.push_back(12'hff4);
    wr(`VILU_ADDR_OPTION, 8'h30);
    wait_q;
    do_ret;
    wr(`VILU_ADDR_OPTION, 8'h10);
    req_n <= 7'h7e;
    exp_q.push_back(12'hff6);
    wait_q;
    // The non-maskable flag is still latched from the disabled capture; enabling it pre-empts
    exp_q.push_back(12'hffc);
    wr(`VILU_ADDR_LATCH, 8'h02);
    wait_q;
    do_ret;
    wr(`VILU_ADDR_LATCH, 8'h06);
    req_n <= 7'h7f;
    do_ret;
    $display("test preempt done");
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset mode", core_mode, `VILU_MODE_NMI);
    rd(`VILU_ADDR_LATCH);
    check("latch reset", rd_val & 8'he4, 8'h80);
    do_ret;
    $display("test reset again done");
    report_and_stop;
  end
endmodule
